// [core/adc_clock_format_window.sv]
`timescale 1ns/1ps
`default_nettype none
`include "adc_window_params.svh"
module adc_clock_format_window
  import adc_window_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata,
  input wire conv_result_s conv_in,
  input wire logic diff_mode,
  input wire logic conv_busy,
  output logic conv_clk_en,
  output logic conv_start,
  output logic window_event
);

  // ****************************************************
  // register state
  // ****************************************************
  logic [7:0] config_q, config_d; // divider and justify
  logic [7:0] res_low_q, res_low_d; // result low byte
  logic [7:0] res_high_q, res_high_d; // result high byte
  logic [7:0] control_q, control_d; // control and flags
  logic [7:0] gt_low_q, gt_low_d; // greater limit low
  logic [7:0] gt_high_q, gt_high_d; // greater limit high
  logic [7:0] lt_low_q, lt_low_d; // less limit low
  logic [7:0] lt_high_q, lt_high_d; // less limit high
  logic [7:0] rdata_q, rdata_d; // registered read data
  logic start_q, start_d; // start request pulse
  logic event_q, event_d; // window hit pulse

  // ****************************************************
  // conversion clock divider
  // ****************************************************
  logic [`DIV_W-1:0] div_cnt_q, div_cnt_d; // cycles since last enable
  logic [`DIV_W-1:0] div_val; // programmed divider
  logic div_tick; // one-cycle conversion clock enable

  assign div_val = config_q[`DIV_MSB:`DIV_LSB]; // [RULE2]
  assign div_tick = (div_cnt_q >= div_val);

  // count to divider value: period is divider plus one cycles
  always_comb begin
    if (div_tick) begin
      div_cnt_d = '0; // [RULE1]
    end else begin
      div_cnt_d = div_cnt_q + `DIV_W'(1);
    end
  end

  // divider register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_d;
    end
  end

  assign conv_clk_en = div_tick;

  // ****************************************************
  // result formatting
  // ****************************************************
  logic [15:0] new_word; // incoming result as a register pair
  logic justify_select; // left justify when set
  logic [`PAD_W-1:0] pad; // fill above a right-justified result

  assign justify_select = config_q[`JUST_BIT];

  // place result; sign extend in differential right mode
  always_comb begin
    pad = diff_mode ? {`PAD_W{conv_in.data[`RES_W-1]}} : '0;
    if (justify_select) begin
      new_word = {conv_in.data, {`PAD_W{1'b0}}}; // [RULE13]
    end else begin
      new_word = {pad, conv_in.data}; // [RULE13]
    end
  end

  // ****************************************************
  // window detector
  // ****************************************************
  logic win_hit; // new result lies in the window

  window_compare u_window_compare (
    .word(new_word),
    .gt_limit({gt_high_q, gt_low_q}), // [RULE6]
    .lt_limit({lt_high_q, lt_low_q}), // [RULE7]
    .signed_mode(diff_mode),
    .hit(win_hit),
    .kind()
  );

  // ****************************************************
  // register writes, hardware updates, read mux
  // ****************************************************
  always_comb begin
    config_d = config_q;
    res_low_d = res_low_q;
    res_high_d = res_high_q;
    control_d = control_q;
    gt_low_d = gt_low_q;
    gt_high_d = gt_high_q;
    lt_low_d = lt_low_q;
    lt_high_d = lt_high_q;
    start_d = 1'b0;
    event_d = 1'b0;
    rdata_d = 8'h00;
    // software writes
    if (sfr_req.wr) begin
      unique case (sfr_req.addr)
        `ADDR_CONFIG: begin
          config_d = sfr_req.wdata & `CFG_RO_MASK; // [RULE2]
        end
        `ADDR_RES_LOW: begin
          res_low_d = sfr_req.wdata;
        end
        `ADDR_RES_HIGH: begin
          res_high_d = sfr_req.wdata;
        end
        `ADDR_CONTROL: begin
          control_d = sfr_req.wdata;
          control_d[`BUSY_BIT] = 1'b0;
          // flags clear on 0, a 1 leaves them as they were
          control_d[`WIN_BIT] = control_q[`WIN_BIT] & sfr_req.wdata[`WIN_BIT]; // [RULE5]
          control_d[`CONV_DONE_BIT] = control_q[`CONV_DONE_BIT] & sfr_req.wdata[`CONV_DONE_BIT];
          start_d = sfr_req.wdata[`BUSY_BIT];
        end
        `ADDR_GT_LOW: begin
          gt_low_d = sfr_req.wdata;
        end
        `ADDR_GT_HIGH: begin
          gt_high_d = sfr_req.wdata;
        end
        `ADDR_LT_LOW: begin
          lt_low_d = sfr_req.wdata;
        end
        `ADDR_LT_HIGH: begin
          lt_high_d = sfr_req.wdata;
        end
        default: begin
          // unmapped address: ignored
        end
      endcase
    end
    // new result: load pair and judge it; set beats a same-cycle clear
    if (conv_in.done) begin
      res_high_d = new_word[15:8];
      res_low_d = new_word[7:0];
      control_d[`CONV_DONE_BIT] = 1'b1;
      if (win_hit) begin
        control_d[`WIN_BIT] = 1'b1; // [RULE3] [RULE4]
        event_d = 1'b1; // [RULE4]
      end
    end
    // read data for the address presented this cycle
    unique case (sfr_req.addr)
      `ADDR_CONFIG: begin
        rdata_d = config_q;
      end
      `ADDR_RES_LOW: begin
        rdata_d = res_low_q;
      end
      `ADDR_RES_HIGH: begin
        rdata_d = res_high_q;
      end
      `ADDR_CONTROL: begin
        rdata_d = control_q;
        rdata_d[`BUSY_BIT] = conv_busy;
      end
      `ADDR_GT_LOW: begin
        rdata_d = gt_low_q;
      end
      `ADDR_GT_HIGH: begin
        rdata_d = gt_high_q;
      end
      `ADDR_LT_LOW: begin
        rdata_d = lt_low_q;
      end
      `ADDR_LT_HIGH: begin
        rdata_d = lt_high_q;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // register bank
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      config_q <= `RST_CONFIG;
      res_low_q <= `RST_RESULT;
      res_high_q <= `RST_RESULT;
      control_q <= `RST_CONTROL;
      gt_low_q <= `RST_GT;
      gt_high_q <= `RST_GT;
      lt_low_q <= `RST_LT;
      lt_high_q <= `RST_LT;
      rdata_q <= 8'h00;
      start_q <= 1'b0;
      event_q <= 1'b0;
    end else begin
      config_q <= config_d;
      res_low_q <= res_low_d;
      res_high_q <= res_high_d;
      control_q <= control_d;
      gt_low_q <= gt_low_d;
      gt_high_q <= gt_high_d;
      lt_low_q <= lt_low_d;
      lt_high_q <= lt_high_d;
      rdata_q <= rdata_d;
      start_q <= start_d;
      event_q <= event_d;
    end
  end

  assign sfr_rdata = rdata_q;
  assign conv_start = start_q;
  assign window_event = event_q;

endmodule : adc_clock_format_window
`default_nettype wire

// [core/adc_window_params.svh]
// Functional notes
// RULE1 - conversion clock period is divider plus one
// RULE2 - five-bit divider in config bits seven to three
// RULE3 - every new result is compared automatically
// RULE4 - window hit sets flag and pulses event
// RULE5 - flag readable in control, software clears it
// RULE6 - greater limit built from high and low bytes
// RULE7 - less limit built from high and low bytes
// RULE8 - inside or outside chosen by limit order
// RULE9 - inside: above greater and below less limit
// RULE10 - single-ended compares as unsigned numbers
// RULE11 - differential compares as signed two's complement
// RULE12 - outside: below less or above greater limit
// RULE13 - justify bit picks right or left placement
`ifndef ADC_WINDOW_PARAMS_SVH
`define ADC_WINDOW_PARAMS_SVH

// ****************************************************
// register addresses
// ****************************************************
`define ADDR_CONFIG 8'hbc
`define ADDR_RES_LOW 8'hbd
`define ADDR_RES_HIGH 8'hbe
`define ADDR_CONTROL 8'he8
`define ADDR_GT_LOW 8'hc3
`define ADDR_GT_HIGH 8'hc4
`define ADDR_LT_LOW 8'hc5
`define ADDR_LT_HIGH 8'hc6

// ****************************************************
// reset values
// ****************************************************
`define RST_CONFIG 8'hf8
`define RST_RESULT 8'h00
`define RST_CONTROL 8'h00
`define RST_GT 8'hff
`define RST_LT 8'h00

// ****************************************************
// field positions and widths
// ****************************************************
`define DIV_W 5
`define DIV_MSB 7
`define DIV_LSB 3
`define JUST_BIT 2
`define CFG_RO_MASK 8'hfc
`define CONV_DONE_BIT 5
`define BUSY_BIT 4
`define WIN_BIT 3
`define RES_W 10
`define PAD_W 6

`endif

// [core/adc_window_pkg.sv]
package adc_window_pkg;

  // one finished conversion from the analog side
  typedef struct packed {
    logic done;
    logic [9:0] data;
  } conv_result_s;

  // register bus request
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

  // kind of window that the limits describe
  typedef enum logic {
    WIN_INSIDE,
    WIN_OUTSIDE
  } window_kind_e;

endpackage : adc_window_pkg

// [core/window_compare.sv]
`timescale 1ns/1ps
`default_nettype none
`include "adc_window_params.svh"
module window_compare
  import adc_window_pkg::*;
(
  input wire logic [15:0] word,
  input wire logic [15:0] gt_limit,
  input wire logic [15:0] lt_limit,
  input wire logic signed_mode,
  output logic hit,
  output window_kind_e kind
);

  // strict a > b, signed or unsigned
  function automatic logic above(input logic [15:0] a, input logic [15:0] b, input logic sgn);
    if (sgn) begin
      above = $signed(a) > $signed(b); // [RULE11]
    end else begin
      above = a > b; // [RULE10]
    end
  endfunction : above

  // ****************************************************
  // window decision
  // ****************************************************
  always_comb begin
    // limit order alone picks the window kind
    kind = above(lt_limit, gt_limit, signed_mode) ? WIN_INSIDE : WIN_OUTSIDE; // [RULE8]
    if (kind == WIN_INSIDE) begin
      hit = above(word, gt_limit, signed_mode) && above(lt_limit, word, signed_mode); // [RULE9]
    end else begin
      hit = above(lt_limit, word, signed_mode) || above(word, gt_limit, signed_mode); // [RULE12]
    end
  end

endmodule : window_compare
`default_nettype wire

// [sim/adc_window_sva.sv]
`timescale 1ns/1ps
`default_nettype none
`include "adc_window_params.svh"
module adc_window_sva
  import adc_window_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire sfr_req_s sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire conv_result_s conv_in,
  input wire logic diff_mode,
  input wire logic conv_busy,
  input wire logic conv_clk_en,
  input wire logic conv_start,
  input wire logic window_event
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ****************
  // shadow state
  // ****************
  logic [7:0] cfg_q; // config copy
  logic [15:0] gt_q; // greater limit copy
  logic [15:0] lt_q; // less limit copy
  logic [5:0] cnt_q; // cycles since last enable
  logic wrote_q; // config written since last enable
  logic [15:0] word; // formatted result
  logic signed [16:0] ws, gs, ls; // compare operands
  logic hit; // expected window outcome
  // follows register writes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_q <= `RST_CONFIG;
      gt_q <= 16'hffff;
      lt_q <= 16'h0000;
    end else if (sfr_req.wr) begin
      case (sfr_req.addr)
        `ADDR_CONFIG: cfg_q <= sfr_req.wdata;
        `ADDR_GT_LOW: gt_q[7:0] <= sfr_req.wdata;
        `ADDR_GT_HIGH: gt_q[15:8] <= sfr_req.wdata;
        `ADDR_LT_LOW: lt_q[7:0] <= sfr_req.wdata;
        `ADDR_LT_HIGH: lt_q[15:8] <= sfr_req.wdata;
        default: ;
      endcase
    end
  end
  // period counter; a divider change makes one period unreliable
  always_ff @(posedge clk_sys) begin
    cnt_q <= (srst || conv_clk_en) ? 6'h00 : cnt_q + 6'h01;
    if (srst) wrote_q <= 1'b0;
    else if (sfr_req.wr && sfr_req.addr == `ADDR_CONFIG) wrote_q <= 1'b1;
    else if (conv_clk_en) wrote_q <= 1'b0;
  end
  // window outcome from placement and signedness
  always_comb begin
    word = cfg_q[2] ? {conv_in.data, 6'h00} : {{6{diff_mode & conv_in.data[9]}}, conv_in.data};
    ws = {diff_mode & word[15], word};
    gs = {diff_mode & gt_q[15], gt_q};
    ls = {diff_mode & lt_q[15], lt_q};
    hit = (ls > gs) ? (ws > gs && ws < ls) : (ws < ls || ws > gs);
  end
  // ****************
  // assertions
  // ****************
  AST_CLK_DIV: assert property (
    !wrote_q |-> conv_clk_en == (cnt_q == {1'b0, cfg_q[7:3]}))
    else $error("clock enable off period");
  AST_CFG_PAD: assert property (
    $past(sfr_req.addr) == `ADDR_CONFIG |-> sfr_rdata[1:0] == 2'h0)
    else $error("config low bits not zero");
  AST_EVT_CAUSE: assert property (
    window_event |-> $past(conv_in.done))
    else $error("event without result");
  AST_MODE_PICK: assert property (
    conv_in.done |=> window_event == $past(hit))
    else $error("event disagrees with window");
  AST_INSIDE: assert property (
    conv_in.done && ls > gs && ws > gs && ws < ls |=> window_event)
    else $error("inside hit missed");
  AST_OUTSIDE: assert property (
    conv_in.done && !(ls > gs) && (ws < ls || ws > gs) |=> window_event)
    else $error("outside hit missed");
  AST_UNSIGNED: assert property (
    conv_in.done && !diff_mode && !hit |=> !window_event)
    else $error("false hit single-ended");
  AST_SIGNED: assert property (
    conv_in.done && diff_mode && !hit |=> !window_event)
    else $error("false hit differential");
  AST_FLAG_HOLD: assert property (
    sfr_req.addr == `ADDR_CONTROL && $past(sfr_req.addr) == `ADDR_CONTROL && !sfr_req.wr
    && !$past(sfr_req.wr) && sfr_rdata[3] |=> sfr_rdata[3])
    else $error("window flag dropped");
endmodule : adc_window_sva
bind adc_clock_format_window adc_window_sva chk_i (.clk_sys, .srst, .sfr_req, .sfr_rdata, .conv_in,
  .diff_mode, .conv_busy, .conv_clk_en, .conv_start, .window_event);
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "adc_window_params.svh"
module testbench
  import adc_window_pkg::*;
;
  logic clk_sys = 0, srst = 1, diff_mode = 0, conv_busy = 0; // free inputs
  sfr_req_s sfr_req = '0; // register request
  conv_result_s conv_in = '0; // converter result
  logic [7:0] sfr_rdata;
  logic conv_clk_en, conv_start, window_event;
  int err_count = 0, n_compared = 0, cyc = 0, gap;
  int dv[3] = '{0, 3, 31}; // divider values tried
  always #12.5 clk_sys = ~clk_sys;
  adc_clock_format_window uut (.clk_sys, .srst, .sfr_req, .sfr_rdata, .conv_in, .diff_mode,
    .conv_busy, .conv_clk_en, .conv_start, .window_event);
  // ****************
  // access tasks
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) #2;
    sfr_req = {1'b1, a, d};
    @(posedge clk_sys) #2;
    sfr_req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys) #2;
    sfr_req.addr = a;
    @(posedge clk_sys) #2;
    chk(16'(sfr_rdata), 16'(e));
  endtask : rd
  task automatic lim(input logic [15:0] g, input logic [15:0] l);
    wr(`ADDR_GT_HIGH, g[15:8]);
    wr(`ADDR_GT_LOW, g[7:0]);
    wr(`ADDR_LT_HIGH, l[15:8]);
    wr(`ADDR_LT_LOW, l[7:0]);
  endtask : lim
  // clears flags, converts once, checks event and flags
  task automatic cv(input logic [9:0] d, input logic hit);
    wr(`ADDR_CONTROL, 8'h00);
    @(posedge clk_sys) #2;
    conv_in = {1'b1, d};
    @(posedge clk_sys) #2;
    conv_in.done = 1'b0;
    chk(16'(window_event), 16'(hit));
    rd(`ADDR_CONTROL, hit ? 8'h28 : 8'h20);
  endtask : cv
  task end_sim;
    $display("counts: %0d compared, %0d unexpected", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      end_sim;
    end
  end
  // ****************
  // tests
  // ****************
  initial begin
    repeat (12) @(posedge clk_sys);
    #2 srst = 0;
    rd(`ADDR_CONFIG, 8'hf8);
    rd(`ADDR_GT_HIGH, 8'hff);
    rd(`ADDR_LT_LOW, 8'h00);
    rd(8'h00, 8'h00);
    $display("reset values done");
    foreach (dv[i]) begin
      wr(`ADDR_CONFIG, {dv[i][4:0], 3'h3});
      rd(`ADDR_CONFIG, {dv[i][4:0], 3'h0});
      for (int k = 0; k < 40 && !conv_clk_en; k++) @(posedge clk_sys) #2;
      gap = 0;
      do begin
        @(posedge clk_sys) #2;
        gap++;
      end while (!conv_clk_en && gap < 40);
      chk(16'(gap), 16'(dv[i] + 1));
    end
    $display("divider done");
    wr(`ADDR_CONFIG, 8'h18);
    lim(16'h0040, 16'h0080);
    cv(10'h040, 0);
    cv(10'h041, 1);
    cv(10'h080, 0);
    rd(`ADDR_RES_LOW, 8'h80);
    lim(16'h0080, 16'h0040);
    cv(10'h03f, 1);
    cv(10'h060, 0);
    cv(10'h081, 1);
    lim(16'h0040, 16'h0400);
    cv(10'h3ff, 1);
    diff_mode = 1;
    cv(10'h3ff, 0);
    rd(`ADDR_RES_HIGH, 8'hff);
    lim(16'hffff, 16'h0040);
    cv(10'h000, 1);
    cv(10'h040, 0);
    lim(16'h0040, 16'hffff);
    cv(10'h3fe, 1);
    cv(10'h3ff, 0);
    $display("window done");
    diff_mode = 0;
    wr(`ADDR_CONFIG, 8'h1c);
    lim(16'h1000, 16'h2000);
    cv(10'h3ff, 0);
    rd(`ADDR_RES_LOW, 8'hc0);
    cv(10'h060, 1);
    rd(`ADDR_RES_HIGH, 8'h18);
    // result bytes are also plain software storage
    wr(`ADDR_RES_HIGH, 8'h5a);
    rd(`ADDR_RES_HIGH, 8'h5a);
    wr(`ADDR_CONTROL, 8'h08);
    rd(`ADDR_CONTROL, 8'h08);
    // a one in the busy position starts a conversion for exactly one cycle
    wr(`ADDR_CONTROL, 8'h10);
    chk(16'(conv_start), 16'h0001);
    @(posedge clk_sys) #2;
    chk(16'(conv_start), 16'h0000);
    wr(`ADDR_CONTROL, 8'h00);
    conv_busy = 1;
    rd(`ADDR_CONTROL, 8'h10);
    $display("placement and flag done");
    end_sim;
  end
endmodule : testbench
`default_nettype wire
